// ---- adc_seq_defines.svh ----
// register offsets, field positions, write masks and reset values
// assumes a 32-bit apb slave decoding an 8-bit byte address
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CON2        8'h00
`define OFF_CON3        8'h04
`define OFF_CHS123      8'h08
`define OFF_CHS0        8'h0C
`define OFF_SCAN        8'h10
`define OFF_SEQ_CTRL    8'h14
`define OFF_SEQ_STAT    8'h18

// ----------------------------------------
// writable bit masks and reset values
// ----------------------------------------
`define MASK_CON2       16'hE73F
`define MASK_CON3       16'h9F3F
`define MASK_CHS123     16'h0707
`define MASK_CHS0       16'h9F9F
`define MASK_SCAN       16'h03FF
`define MASK_SEQ_CTRL   16'h0003
`define RST_REG16       16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define CON2_REF        15:13
`define CON2_SCAN_EN    10
`define CON2_CH_COUNT   9:8
`define CON2_FILL_HALF  7
`define CON2_SEQ_IRQ    5:2
`define CON2_SPLIT      1
`define CON2_ALT        0
`define CON3_SRC        15
`define CON3_SAMPLE_T   12:8
`define CON3_DIV        5:0
`define CHS123_NEG_B    10:9
`define CHS123_POS_B    8
`define CHS123_NEG_A    2:1
`define CHS123_POS_A    0
`define CHS0_NEG_B      15
`define CHS0_POS_B      12:8
`define CHS0_NEG_A      7
`define CHS0_POS_A      4:0
`define CTRL_ENABLE     0
`define CTRL_RES_MODE   1

`endif

// ---- adc_seq_pkg.sv ----
// types shared by the converter sequence and channel control
// assumes adc_seq_defines.svh holds every number
package adc_seq_pkg;

    // ----------------------------------------
    // routing types
    // ----------------------------------------
    typedef enum logic [1:0] {
        GRP_NEG_REF,
        GRP_NEG_AN6_8,
        GRP_NEG_AN9_NC
    } grp_neg_t;

    typedef struct packed {
        logic pos_ext;
        logic neg_ext;
    } ref_route_t;

    typedef struct packed {
        logic [4:0] ch0_pos;
        logic       ch0_pos_neg_ref;
        logic       ch0_neg_an1;
        logic       grp_enable;
        logic       grp_pos_upper;
        grp_neg_t   grp_neg;
        logic [1:0] chan_count;
    } input_route_t;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } seq_state_t;

endpackage

// ---- adc_sequence_channel_control.sv ----
// converter control: registers, conversion clock, sample/convert sequencing
// assumes rc_clk_in is asynchronous; apb and everything else run on clk
`include "adc_seq_defines.svh"

// Operation
// - reference select 000 supply, 001 ext pos, 010 ext neg, 011 both, 1xx supply.
// - scan enable takes channel 0 positive input during Sample A from scan list.
// - channel count 00 converts ch0, 01 ch0 and ch1, 1x all four.
// - in 12-bit mode channel count reads zero and only ch0 converts.
// - fill status reads 1 while second half fills, 0 for first half.
// - interrupt after every sequences_per_irq plus one completed sequences.
// - split mode fills first half until interrupt, then second, alternating.
// - without split mode results restart at first location after each interrupt.
// - alternate mode swaps Sample A and Sample B selects each sample.
// - clock source bit 1 uses internal rc, 0 uses system derived clock.
// - auto sampling lasts sample-time field conversion clock periods, 0 to 31.
// - derived conversion clock period is divider field plus one system cycles.
// - group positive bit set selects AN3-AN5, clear AN0-AN2, 10-bit only.
// - group negative 00/01 negative reference, 10 AN6-AN8, 11 AN9 and open.
// - channel 0 negative bit 1 selects AN1, 0 negative reference.
// - channel 0 positive select routes the input with that number.
// - scanning includes inputs whose scan bit is set, skips cleared ones.
// - all scan bits writable; missing inputs convert negative reference.
// - resolution mode set is 12-bit single channel, clear 10-bit four channel.
module adc_sequence_channel_control
    import adc_seq_pkg::*;
#(
    parameter int NUM_INPUTS    = 10,
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int CONV_TADS     = 12
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rc_clk_in,
    output logic             conv_tick,
    output logic             sampling,
    output logic             converting,
    output logic             result_write,
    output logic      [3:0]  result_addr,
    output logic      [1:0]  result_channel,
    output logic             seq_irq,
    output logic             fill_half_status,
    output ref_route_t       ref_route,
    output input_route_t     route
);

    // ----------------------------------------
    // register file state
    // ----------------------------------------
    logic [15:0] con2_reg;
    logic [15:0] con3_reg;
    logic [15:0] chs123_reg;
    logic [15:0] chs0_reg;
    logic [15:0] scan_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] rd_data;
    logic        rd_hit;
    logic        access;
    logic        wr_en;

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    seq_state_t  state_reg;
    logic [5:0]  div_cnt_reg;
    logic [5:0]  tad_cnt_reg;
    logic [1:0]  chan_reg;
    logic [3:0]  seq_cnt_reg;
    logic        use_b_reg;
    logic [3:0]  scan_pos_reg;
    logic        half_reg;
    logic [3:0]  addr_reg;
    logic        rc_meta_reg;
    logic        rc_sync_reg;
    logic        rc_prev_reg;
    logic        tad;
    logic        res_mode;
    logic [1:0]  chan_last;
    logic [3:0]  scan_cur;
    logic        chan_end;
    logic        seq_end;
    logic        irq_now;
    input_route_t route_next;

    assign access   = psel & penable;
    assign wr_en    = access & pready & pwrite;
    assign res_mode = ctrl_reg[`CTRL_RES_MODE];

    // lowest enabled input at or above from, else lowest enabled overall
    function automatic logic [3:0] scan_pick(input logic [3:0] from,
                                             input logic [9:0] bits);
        logic [3:0] pick;
        pick = from;
        for (int i = 9; i >= 0; i--) begin
            if (bits[i]) begin
                pick = 4'(i);
            end
        end
        for (int i = 9; i >= 0; i--) begin
            if (bits[i] && (4'(i) >= from)) begin
                pick = 4'(i);
            end
        end
        return pick;
    endfunction

    // ----------------------------------------
    // apb read mux
    // ----------------------------------------
    always_comb begin
        rd_hit  = 1'b1;
        rd_data = `RST_REG16;
        unique case (paddr)
            `OFF_CON2: begin
                rd_data = con2_reg;
                if (res_mode) begin
                    rd_data[`CON2_CH_COUNT] = 2'b00;
                end
                rd_data[`CON2_FILL_HALF] = half_reg;
            end
            `OFF_CON3:     rd_data = con3_reg;
            `OFF_CHS123:   rd_data = chs123_reg;
            `OFF_CHS0:     rd_data = chs0_reg;
            `OFF_SCAN:     rd_data = scan_reg;
            `OFF_SEQ_CTRL: rd_data = ctrl_reg;
            `OFF_SEQ_STAT: begin
                rd_data = {4'h0, seq_cnt_reg, addr_reg, use_b_reg,
                           chan_reg, (state_reg != ST_IDLE)};
            end
            default:       rd_hit = 1'b0;
        endcase
    end

    // ----------------------------------------
    // apb handshake: answer in second access cycle
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            if (access & ~pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_data};
                pslverr <= ~rd_hit;
            end else begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            con2_reg   <= `RST_REG16;
            con3_reg   <= `RST_REG16;
            chs123_reg <= `RST_REG16;
            chs0_reg   <= `RST_REG16;
            scan_reg   <= `RST_REG16;
            ctrl_reg   <= `RST_REG16;
        end else if (wr_en) begin
            unique case (paddr)
                `OFF_CON2:     con2_reg   <= pwdata[15:0] & `MASK_CON2;
                `OFF_CON3:     con3_reg   <= pwdata[15:0] & `MASK_CON3;
                `OFF_CHS123:   chs123_reg <= pwdata[15:0] & `MASK_CHS123;
                `OFF_CHS0:     chs0_reg   <= pwdata[15:0] & `MASK_CHS0;
                `OFF_SCAN:     scan_reg   <= pwdata[15:0] & `MASK_SCAN;
                `OFF_SEQ_CTRL: ctrl_reg   <= pwdata[15:0] & `MASK_SEQ_CTRL;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // conversion clock
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rc_meta_reg <= 1'b0;
            rc_sync_reg <= 1'b0;
            rc_prev_reg <= 1'b0;
        end else begin
            rc_meta_reg <= rc_clk_in;
            rc_sync_reg <= rc_meta_reg;
            rc_prev_reg <= rc_sync_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_cnt_reg <= 6'h00;
        end else if (div_cnt_reg >= con3_reg[`CON3_DIV]) begin
            div_cnt_reg <= 6'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    always_comb begin
        if (con3_reg[`CON3_SRC]) begin
            tad = rc_sync_reg & ~rc_prev_reg;
        end else begin
            tad = (div_cnt_reg >= con3_reg[`CON3_DIV]);
        end
    end

    // ----------------------------------------
    // sequence decode
    // ----------------------------------------
    always_comb begin
        if (res_mode) begin
            chan_last = 2'b00;
        end else if (con2_reg[9]) begin
            chan_last = 2'b11;
        end else if (con2_reg[8]) begin
            chan_last = 2'b01;
        end else begin
            chan_last = 2'b00;
        end
    end

    assign scan_cur = scan_pick(scan_pos_reg, scan_reg[9:0]);
    assign chan_end = (state_reg == ST_CONVERT) && tad &&
                      (tad_cnt_reg == 6'(CONV_TADS - 1));
    assign seq_end  = chan_end && (chan_reg == chan_last);
    assign irq_now  = seq_end && (seq_cnt_reg == con2_reg[`CON2_SEQ_IRQ]);

    // ----------------------------------------
    // sample/convert state machine
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg   <= ST_IDLE;
            tad_cnt_reg <= 6'h00;
            chan_reg    <= 2'b00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    tad_cnt_reg <= 6'h00;
                    chan_reg    <= 2'b00;
                    if (ctrl_reg[`CTRL_ENABLE]) begin
                        state_reg <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (tad_cnt_reg >= {1'b0, con3_reg[`CON3_SAMPLE_T]}) begin
                        state_reg   <= ST_CONVERT;
                        tad_cnt_reg <= 6'h00;
                    end else if (tad) begin
                        tad_cnt_reg <= tad_cnt_reg + 6'h01;
                    end
                end
                ST_CONVERT: begin
                    if (seq_end) begin
                        chan_reg    <= 2'b00;
                        tad_cnt_reg <= 6'h00;
                        state_reg   <= ctrl_reg[`CTRL_ENABLE] ? ST_SAMPLE : ST_IDLE;
                    end else if (chan_end) begin
                        chan_reg    <= chan_reg + 2'b01;
                        tad_cnt_reg <= 6'h00;
                    end else if (tad) begin
                        tad_cnt_reg <= tad_cnt_reg + 6'h01;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // interrupt rate and buffer fill
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_cnt_reg <= 4'h0;
        end else if (irq_now) begin
            seq_cnt_reg <= 4'h0;
        end else if (seq_end) begin
            seq_cnt_reg <= seq_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            half_reg <= 1'b0;
            addr_reg <= 4'h0;
        end else if (irq_now) begin
            if (con2_reg[`CON2_SPLIT]) begin
                half_reg <= ~half_reg;
                addr_reg <= {~half_reg, 3'b000};
            end else begin
                half_reg <= 1'b0;
                addr_reg <= 4'h0;
            end
        end else if (chan_end) begin
            if (con2_reg[`CON2_SPLIT]) begin
                addr_reg <= {half_reg, addr_reg[2:0] + 3'b001};
            end else begin
                addr_reg <= addr_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // sample a/b alternation and scanning
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            use_b_reg <= 1'b0;
        end else if (!con2_reg[`CON2_ALT]) begin
            use_b_reg <= 1'b0;
        end else if (seq_end) begin
            use_b_reg <= ~use_b_reg;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scan_pos_reg <= 4'h0;
        end else if (!con2_reg[`CON2_SCAN_EN]) begin
            scan_pos_reg <= 4'h0;
        end else if (seq_end && !use_b_reg) begin
            scan_pos_reg <= scan_pick(scan_cur + 4'h1, scan_reg[9:0]);
        end
    end

    // ----------------------------------------
    // input routing
    // ----------------------------------------
    always_comb begin
        route_next = '0;
        if (con2_reg[`CON2_SCAN_EN] && !use_b_reg) begin
            route_next.ch0_pos = {1'b0, scan_cur};
        end else if (use_b_reg) begin
            route_next.ch0_pos = chs0_reg[`CHS0_POS_B];
        end else begin
            route_next.ch0_pos = chs0_reg[`CHS0_POS_A];
        end
        route_next.ch0_pos_neg_ref = (route_next.ch0_pos >= 5'(NUM_INPUTS));
        route_next.ch0_neg_an1 = use_b_reg ? chs0_reg[`CHS0_NEG_B]
                                           : chs0_reg[`CHS0_NEG_A];
        route_next.chan_count = res_mode ? 2'b00 : con2_reg[`CON2_CH_COUNT];
        route_next.grp_enable = !res_mode && (chan_last != 2'b00);
        if (!res_mode) begin
            route_next.grp_pos_upper = use_b_reg ? chs123_reg[`CHS123_POS_B]
                                                 : chs123_reg[`CHS123_POS_A];
            unique case (use_b_reg ? chs123_reg[`CHS123_NEG_B]
                                   : chs123_reg[`CHS123_NEG_A])
                2'b10:   route_next.grp_neg = LARGE_VARIANT ? GRP_NEG_AN6_8
                                                            : GRP_NEG_REF;
                2'b11:   route_next.grp_neg = LARGE_VARIANT ? GRP_NEG_AN9_NC
                                                            : GRP_NEG_REF;
                default: route_next.grp_neg = GRP_NEG_REF;
            endcase
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            route            <= '0;
            ref_route        <= '0;
            conv_tick        <= 1'b0;
            sampling         <= 1'b0;
            converting       <= 1'b0;
            result_write     <= 1'b0;
            result_addr      <= 4'h0;
            result_channel   <= 2'b00;
            seq_irq          <= 1'b0;
            fill_half_status <= 1'b0;
        end else begin
            route <= route_next;
            ref_route.pos_ext <= (con2_reg[15:13] == 3'b001) ||
                                 (con2_reg[15:13] == 3'b011);
            ref_route.neg_ext <= (con2_reg[15:13] == 3'b010) ||
                                 (con2_reg[15:13] == 3'b011);
            conv_tick        <= tad;
            sampling         <= (state_reg == ST_SAMPLE);
            converting       <= (state_reg == ST_CONVERT);
            result_write     <= chan_end;
            result_addr      <= addr_reg;
            result_channel   <= chan_reg;
            seq_irq          <= irq_now;
            fill_half_status <= half_reg;
        end
    end

endmodule

// ---- adc_sequence_channel_control_asserts.sv ----
// checker for apb answer timing, reference routing and sequencer outputs
// assumes it is bound to adc_sequence_channel_control and sees only its ports
`include "adc_seq_defines.svh"
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic         sampling,
    input wire logic         converting,
    input wire logic         seq_irq,
    input wire ref_route_t   ref_route,
    input wire input_route_t route
);
    // ----------------------------------------
    // shadow of written mode fields
    // ----------------------------------------
    logic       acc;
    logic       res_q;
    logic [2:0] ref_q;
    assign acc = psel && penable && pready && pwrite;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_q <= 1'b0;
            ref_q <= 3'h0;
        end else if (acc && paddr == `OFF_SEQ_CTRL) begin
            res_q <= pwdata[1];
        end else if (acc && paddr == `OFF_CON2) begin
            ref_q <= pwdata[15:13];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_answer_delay: assert property ($rose(penable) && psel |=> pready && psel && penable)
        else $error("pready late");
    a_slverr_map: assert property (pready |-> pslverr == (paddr > `OFF_SEQ_STAT))
        else $error("pslverr wrong");
    a_read_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("prdata outside answer");
    a_read_upper: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("prdata upper nonzero");
    a_irq_pulse: assert property (seq_irq |=> !seq_irq)
        else $error("irq too long");
    a_phase_excl: assert property (!(sampling && converting))
        else $error("sample convert overlap");
    a_ref_map: assert property (acc && paddr == `OFF_CON2 |-> ##2
        (ref_route.pos_ext == (!ref_q[2] && ref_q[0]) && ref_route.neg_ext == (!ref_q[2] && ref_q[1])))
        else $error("reference route wrong");
    a_twelve_count: assert property (res_q && $past(res_q, 2) |-> route.chan_count == 2'h0)
        else $error("count nonzero in 12-bit");
    c_irq: cover property (seq_irq);
    c_slverr: cover property (pslverr);
    c_grp_an9: cover property (route.grp_neg == GRP_NEG_AN9_NC);
endmodule

bind adc_sequence_channel_control adc_seq_checker u_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampling(sampling), .converting(converting), .seq_irq(seq_irq),
    .ref_route(ref_route), .route(route)
);

// ---- adc_sequence_channel_control_tb_top.sv ----
// testbench: register access, routing, conversion clock and sequencing
// assumes design, package and checker are compiled before it
`include "adc_seq_defines.svh"
module adc_sequence_channel_control_tb_top;
    import adc_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk = 1'b0, reset = 1'b1, rc_clk = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd;
    logic         pready, pslverr, err, conv_tick, sampling, converting;
    logic         result_write, seq_irq, fill_half_status;
    logic [3:0]   result_addr;
    logic [1:0]   result_channel;
    ref_route_t   ref_route;
    input_route_t route;
    logic [11:0]  rq[$];
    int           error_cnt = 0, n_tests = 0, cyc = 0, irq_cnt = 0;
    always #50 clk = ~clk;
    always #333 rc_clk = ~rc_clk;
    adc_sequence_channel_control #(.CONV_TADS(2)) dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_clk_in(rc_clk), .conv_tick(conv_tick),
        .sampling(sampling), .converting(converting), .result_write(result_write),
        .result_addr(result_addr), .result_channel(result_channel), .seq_irq(seq_irq),
        .fill_half_status(fill_half_status), .ref_route(ref_route), .route(route)
    );
    // ----------------------------------------
    // result monitor and timeout
    // ----------------------------------------
    always @(posedge clk) begin
        if (seq_irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (result_write === 1'b1)
            rq.push_back({fill_half_status, result_addr, result_channel, route.ch0_pos});
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stop();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0]  a[5] = '{`OFF_CON2, `OFF_CON3, `OFF_CHS123, `OFF_CHS0, `OFF_SCAN};
        logic [15:0] m[5] = '{`MASK_CON2, `MASK_CON3, `MASK_CHS123, `MASK_CHS0, `MASK_SCAN};
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset value", {16'h0, `RST_REG16}, rd);
        end
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        check("unmapped write error", 32'h1, {31'h0, err});
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped read", 32'h1, {rd[30:0], err});
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, a[i], 32'hFFFFFFFF);
            apb(1'b0, a[i], 32'h0);
            check("writable bits", {16'h0, m[i]}, rd);
        end
        apb(1'b1, `OFF_SEQ_CTRL, 32'h2);
        apb(1'b0, `OFF_CON2, 32'h0);
        check("12-bit count", 32'hE43F, rd);
        stop();
        $display("test registers done");
    endtask
    task automatic t_ref();
        for (int v = 0; v < 8; v++) begin
            apb(1'b1, `OFF_CON2, 32'(v) << 13);
            @(posedge clk);
            check("reference route", {30'h0, v < 4 && v[0], v < 4 && v[1]}, {30'h0, ref_route});
        end
        $display("test reference done");
    endtask
    task automatic t_route();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `OFF_CHS123, 32'((c << 1) | (c & 1)));
            @(posedge clk);
            check("group route", {c[0], c[1] ? (c[0] ? GRP_NEG_AN9_NC : GRP_NEG_AN6_8) : GRP_NEG_REF},
                  {route.grp_pos_upper, route.grp_neg});
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `OFF_CHS0, {24'h0, i[0], 2'h0, 5'(i * 4 + 1)});
            @(posedge clk);
            check("ch0 route", {i[0], 5'(i * 4 + 1)}, {route.ch0_neg_an1, route.ch0_pos});
        end
        $display("test routing done");
    endtask
    task automatic tick_gap(logic [15:0] c3, int lo, int hi);
        int g;
        apb(1'b1, `OFF_CON3, {16'h0, c3});
        apb(1'b1, `OFF_SEQ_CTRL, 32'h1);
        while (conv_tick !== 1'b1) @(posedge clk);
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (conv_tick !== 1'b1);
        check("tick spacing", 32'h1, {31'h0, g >= lo && g <= hi});
        stop();
    endtask
    task automatic t_tick();
        tick_gap(16'h0003, 4, 4);
        tick_gap(16'h003F, 64, 64);
        tick_gap(16'h8000, 6, 7);
        $display("test conversion clock done");
    endtask
    task automatic samp_len(logic [4:0] s, output int len);
        apb(1'b1, `OFF_CON3, {19'h0, s, 8'h00});
        apb(1'b1, `OFF_SEQ_CTRL, 32'h1);
        while (sampling !== 1'b1) @(posedge clk);
        len = 0;
        while (sampling === 1'b1) begin
            @(posedge clk);
            len++;
        end
        stop();
    endtask
    task automatic t_samp();
        int a, b;
        samp_len(5'h00, a);
        samp_len(5'h1F, b);
        check("sample time", 32'h1F, 32'(b - a));
        $display("test sample time done");
    endtask
    task automatic run_seq(logic [15:0] c2, int irqs, int sz, int ch, logic [19:0] pos);
        int          b, per, s, h;
        logic [11:0] e, m;
        apb(1'b1, `OFF_CON3, 32'h1F00);
        apb(1'b1, `OFF_CON2, {16'h0, c2});
        rq.delete();
        b = irq_cnt;
        apb(1'b1, `OFF_SEQ_CTRL, 32'h1);
        while (irq_cnt < b + irqs) @(posedge clk);
        check("result count", 32'(sz), 32'(rq.size()));
        stop();
        per = sz / irqs;
        m = c2[1] ? 12'hFFF : 12'h7FF;
        for (int i = 0; i < sz && i < rq.size(); i++) begin
            h = (i / per) % 2;
            s = (i / ch) % 4;
            e = {h[0], c2[1] ? {h[0], 3'(i % per)} : 4'(i % per), 2'(i % ch), pos[5 * s +: 5]};
            check("result entry", {20'h0, e & m}, {20'h0, rq[i] & m});
        end
    endtask
    task automatic t_seq();
        apb(1'b1, `OFF_CHS0, 32'h0);
        run_seq(16'h0104, 2, 8, 2, 20'h0);
        run_seq(16'h003C, 1, 16, 1, 20'h0);
        run_seq(16'h0202, 3, 12, 4, 20'h0);
        apb(1'b1, `OFF_CHS0, 32'h0703);
        run_seq(16'h0001, 4, 4, 1, 20'h38CE3);
        apb(1'b1, `OFF_SCAN, 32'h0212);
        run_seq(16'h0400, 4, 4, 1, 20'h0A481);
        $display("test sequencing done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_regs();
        t_ref();
        t_route();
        t_tick();
        t_samp();
        t_seq();
        final_report();
    end
endmodule
